// ---- hw/brc_pkg.sv ----
package brc_pkg;
  // Register byte addresses
  localparam logic [3:0] REG_REF_CTRL     = 4'h0;
  localparam logic [3:0] REG_DET_CTRL     = 4'h4;
  localparam logic [3:0] REG_LOW_FLAG     = 4'h8;
  localparam logic [3:0] REG_SYS_CTRL     = 4'hC;
  // Field positions, analog_reference_control
  localparam int HIGH_REF_EN_BIT   = 7;
  localparam int LOW_REF_EN_BIT    = 6;
  localparam int HIGH_REF_OE_BIT   = 5;
  localparam int LOW_REF_OE_BIT    = 4;
  // Field positions, supply_detect_control
  localparam int BG_STABLE_BIT     = 5;
  localparam int DET_EN_BIT        = 4;
  localparam int TRIP_LSB          = 0;
  localparam int TRIP_W            = 4;
  // Field positions, own registers
  localparam int LOW_FLAG_BIT      = 0;
  localparam int LOW_IRQ_EN_BIT    = 1;
  localparam int BROWNOUT_EN_BIT   = 0;
  localparam int ASYNC_STABLE_BIT  = 1;
  // Reset values and external trip code
  localparam logic [7:0] REF_CTRL_RST = 8'h00;
  localparam logic [3:0] TRIP_RST     = 4'h5;
  localparam logic [3:0] TRIP_EXTERNAL = 4'hF;
  // Timing
  localparam int CLK_MHZ          = 250;
  localparam int BG_STARTUP_US    = 50;
  localparam int BG_STARTUP_CYC   = BG_STARTUP_US * CLK_MHZ;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    BRC_BG_OFF    = 2'b00,
    BRC_BG_START  = 2'b01,
    BRC_BG_STABLE = 2'b10
  } brc_bg_e;
endpackage

// ---- hw/brc_ctrl.sv ----
// The register addresses and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
// Operation
// (RQ1) Bandgap powered while any user enabled
// (RQ2) Bit 7 enables high internal reference
// (RQ3) Bit 6 enables low internal reference
// (RQ4) Pin output only while reference enabled
// (RQ5) Pin otherwise stays general purpose I/O
// (RQ6) Bandgap stable within 50 us
// (RQ7) Software waits for stable before use
// (RQ8) Detect control bit 4 enables detector
// (RQ9) Low supply sets flag, requests interrupt
// (RQ10) Low supply interrupt wakes from sleep
// (RQ11) Bits 3:0 choose trip level
// (RQ12) Flag clear ignored while supply low
// (RQ13) Software clears irq enable after first
// (RQ14) Program trip level before enable
// (RQ15) Flag blocked until bandgap stable
// (RQ16) Stable flag at detect control bit 5
// (RQ17) Code 1111 selects external trip pin
// (RQ18) Software avoids unused trip codes
// (RQ19) Detector off powers bandgap down if unused
// (RQ20) Stable flag read-only, bits 7:6 zero
// (RQ21) Stability by macro input or counter
// (RQ22) Reference control low bits read zero
module brc_ctrl
  import brc_pkg::*;
#(
  parameter int STARTUP_CYCLES = BG_STARTUP_CYC
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  // AXI4-Lite write
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Analog macro
  input  wire logic        low_supply_cmp_i,
  input  wire logic        bg_ready_i,
  input  wire logic        sleep_i,
  output logic             bg_power_o,
  output logic             high_ref_amp_en_o,
  output logic             low_ref_amp_en_o,
  output logic             trip_ext_sel_o,
  output logic [3:0]       trip_level_o,
  output logic             high_ref_pin_drive_o,
  output logic             low_ref_pin_drive_o,
  // System
  output logic             low_supply_irq_o,
  output logic             wake_o
);

  // Register state
  logic [3:0] ref_ctrl_r;
  logic       det_en_r;
  logic [3:0] trip_r;
  logic       irq_en_r;
  logic       flag_r;
  logic       brownout_en_r;
  logic       use_macro_r;
  brc_bg_e    bg_state_r;
  logic [31:0] bg_cnt_r;
  logic       cmp_s1_r, cmp_s2_r, rdy_s1_r, rdy_s2_r;

  // Write channel state
  logic        aw_hold_r, w_hold_r;
  logic [3:0]  aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        do_write;
  logic        bg_need, bg_stable;

  function automatic logic reg_mapped(input logic [3:0] a);
    reg_mapped = (a == REG_REF_CTRL) || (a == REG_DET_CTRL) ||
                 (a == REG_LOW_FLAG) || (a == REG_SYS_CTRL);
  endfunction

  // Synchronisers for analog inputs
  always_ff @(posedge clk_i or negedge nrst_i)
    if (!nrst_i)
    begin
      cmp_s1_r <= 1'b0;
      cmp_s2_r <= 1'b0;
      rdy_s1_r <= 1'b0;
      rdy_s2_r <= 1'b0;
    end
    else
    begin
      cmp_s1_r <= low_supply_cmp_i;
      cmp_s2_r <= cmp_s1_r;
      rdy_s1_r <= bg_ready_i;
      rdy_s2_r <= rdy_s1_r;
    end

  assign bg_need = brownout_en_r | det_en_r |
                   ref_ctrl_r[3] | ref_ctrl_r[2]; // RQ1 RQ19
  assign bg_stable = (bg_state_r == BRC_BG_STABLE);

  // Write address and data capture, either order
  assign do_write = aw_hold_r && w_hold_r && !s_axi_bvalid;
  always_ff @(posedge clk_i or negedge nrst_i)
    if (!nrst_i)
    begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      aw_addr_r <= 4'h0;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !aw_hold_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_hold_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awready && s_axi_awvalid)
      begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wready && s_axi_wvalid)
      begin
        w_hold_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_hold_r    <= 1'b0;
        w_hold_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= reg_mapped(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end

  // Software-written control bits
  always_ff @(posedge clk_i or negedge nrst_i)
    if (!nrst_i)
    begin
      ref_ctrl_r    <= REF_CTRL_RST[7:4];
      det_en_r      <= 1'b0;
      trip_r        <= TRIP_RST;
      irq_en_r      <= 1'b0;
      brownout_en_r <= 1'b0;
      use_macro_r   <= 1'b0;
    end
    else if (do_write && w_strb_r[0])
    begin
      case (aw_addr_r)
        REG_REF_CTRL: ref_ctrl_r <= w_data_r[7:4]; // RQ2 RQ3 RQ22
        REG_DET_CTRL:
        begin
          det_en_r <= w_data_r[DET_EN_BIT]; // RQ8 RQ19
          trip_r   <= w_data_r[TRIP_LSB +: TRIP_W]; // RQ11
        end
        REG_LOW_FLAG: irq_en_r <= w_data_r[LOW_IRQ_EN_BIT];
        REG_SYS_CTRL:
        begin
          brownout_en_r <= w_data_r[BROWNOUT_EN_BIT];
          use_macro_r   <= w_data_r[ASYNC_STABLE_BIT];
        end
        default: ;
      endcase
    end

  // Bandgap start-up tracking
  always_ff @(posedge clk_i or negedge nrst_i)
    if (!nrst_i)
    begin
      bg_state_r <= BRC_BG_OFF;
      bg_cnt_r   <= 32'h0000_0000;
    end
    else if (!bg_need)
    begin
      bg_state_r <= BRC_BG_OFF; // RQ1
      bg_cnt_r   <= 32'h0000_0000;
    end
    else
    begin
      case (bg_state_r)
        BRC_BG_OFF:
        begin
          bg_state_r <= BRC_BG_START; // RQ21
          bg_cnt_r   <= 32'h0000_0000;
        end
        BRC_BG_START:
        begin
          bg_cnt_r <= bg_cnt_r + 32'h0000_0001;
          if (use_macro_r ? rdy_s2_r
              : (bg_cnt_r >= 32'(STARTUP_CYCLES - 1))) // RQ6 RQ21
            bg_state_r <= BRC_BG_STABLE;
        end
        BRC_BG_STABLE: bg_state_r <= BRC_BG_STABLE;
        default: bg_state_r <= BRC_BG_OFF;
      endcase
    end

  // Low supply flag; set wins over clear
  always_ff @(posedge clk_i or negedge nrst_i)
    if (!nrst_i)
      flag_r <= 1'b0;
    else if (det_en_r && bg_stable && cmp_s2_r) // RQ9 RQ12 RQ15
      flag_r <= 1'b1;
    else if (do_write && w_strb_r[0] && aw_addr_r == REG_LOW_FLAG &&
             !w_data_r[LOW_FLAG_BIT])
      flag_r <= 1'b0;

  // Outputs to analog, pins and system
  always_ff @(posedge clk_i or negedge nrst_i)
    if (!nrst_i)
    begin
      bg_power_o           <= 1'b0;
      high_ref_amp_en_o    <= 1'b0;
      low_ref_amp_en_o     <= 1'b0;
      trip_ext_sel_o       <= 1'b0;
      trip_level_o         <= TRIP_RST;
      high_ref_pin_drive_o <= 1'b0;
      low_ref_pin_drive_o  <= 1'b0;
      low_supply_irq_o     <= 1'b0;
      wake_o               <= 1'b0;
    end
    else
    begin
      bg_power_o        <= bg_need; // RQ1 RQ19
      high_ref_amp_en_o <= ref_ctrl_r[3]; // RQ2
      low_ref_amp_en_o  <= ref_ctrl_r[2]; // RQ3
      trip_ext_sel_o    <= (trip_r == TRIP_EXTERNAL); // RQ17
      trip_level_o      <= trip_r;
      high_ref_pin_drive_o <= ref_ctrl_r[3] & ref_ctrl_r[1]; // RQ4 RQ5
      low_ref_pin_drive_o  <= ref_ctrl_r[2] & ref_ctrl_r[0]; // RQ4 RQ5
      low_supply_irq_o  <= flag_r & irq_en_r; // RQ9
      wake_o            <= flag_r & irq_en_r & sleep_i; // RQ10
    end

  // Read channel
  always_ff @(posedge clk_i or negedge nrst_i)
    if (!nrst_i)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arready && s_axi_arvalid)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= reg_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        case (s_axi_araddr)
          REG_REF_CTRL: s_axi_rdata <= {24'h0, ref_ctrl_r, 4'h0}; // RQ22
          REG_DET_CTRL: s_axi_rdata <= {24'h0, 2'b00, bg_stable,
                                        det_en_r, trip_r}; // RQ16 RQ20
          REG_LOW_FLAG: s_axi_rdata <= {30'h0, irq_en_r, flag_r};
          REG_SYS_CTRL: s_axi_rdata <= {30'h0, use_macro_r, brownout_en_r};
          default:      s_axi_rdata <= 32'h0000_0000;
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end

  // Checks
  property p_bg_power;
    @(posedge clk_i) disable iff (!nrst_i)
    1'b1 |=> (bg_power_o == $past(bg_need));
  endproperty
  a_bg_power: assert property (p_bg_power) // RQ1
    else $error("bandgap power not following users");

  property p_pin_gate;
    @(posedge clk_i) disable iff (!nrst_i)
    high_ref_pin_drive_o |-> $past(ref_ctrl_r[3]);
  endproperty
  a_pin_gate: assert property (p_pin_gate) // RQ4
    else $error("high ref pin driven while reference off");

  property p_pin_gate_low;
    @(posedge clk_i) disable iff (!nrst_i)
    low_ref_pin_drive_o |-> $past(ref_ctrl_r[2]);
  endproperty
  a_pin_gate_low: assert property (p_pin_gate_low) // RQ4
    else $error("low ref pin driven while reference off");

  property p_startup;
    @(posedge clk_i) disable iff (!nrst_i)
    $rose(bg_need) && !use_macro_r ##1 bg_need [*8] |->
      !bg_stable || (STARTUP_CYCLES < 8);
  endproperty
  a_startup: assert property (p_startup) // RQ6
    else $error("bandgap stable too early");

  property p_flag_block;
    @(posedge clk_i) disable iff (!nrst_i)
    $rose(flag_r) |-> $past(bg_stable) && $past(det_en_r);
  endproperty
  a_flag_block: assert property (p_flag_block) // RQ15
    else $error("low flag set before bandgap stable");

  property p_flag_sticky;
    @(posedge clk_i) disable iff (!nrst_i)
    $fell(flag_r) |-> !$past(det_en_r && bg_stable && cmp_s2_r);
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) // RQ12
    else $error("low flag cleared while supply low");

  property p_irq;
    @(posedge clk_i) disable iff (!nrst_i)
    flag_r && irq_en_r |=> low_supply_irq_o;
  endproperty
  a_irq: assert property (p_irq) // RQ9
    else $error("interrupt not raised");

  property p_wake;
    @(posedge clk_i) disable iff (!nrst_i)
    wake_o |-> low_supply_irq_o;
  endproperty
  a_wake: assert property (p_wake) // RQ10
    else $error("wake without interrupt");

  property p_ext;
    @(posedge clk_i) disable iff (!nrst_i)
    trip_ext_sel_o |-> trip_level_o == TRIP_EXTERNAL;
  endproperty
  a_ext: assert property (p_ext) // RQ17
    else $error("external trip select mismatch");

  property p_off;
    @(posedge clk_i) disable iff (!nrst_i)
    !bg_need |=> !bg_stable;
  endproperty
  a_off: assert property (p_off) // RQ19
    else $error("stable while bandgap unpowered");

  c_stable: cover property (@(posedge clk_i) $rose(bg_stable));
  c_flag:   cover property (@(posedge clk_i) $rose(flag_r));
  c_wake:   cover property (@(posedge clk_i) $rose(wake_o));
  c_pin:    cover property (@(posedge clk_i) $rose(low_ref_pin_drive_o));

endmodule

// ---- bench/test_brc_ctrl.sv ----
`timescale 1ns/1ps
module test_brc_ctrl
  import brc_pkg::*;
;
  logic        clk_i;
  logic        nrst_i;
  logic [3:0]  s_axi_awaddr;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic [3:0]  s_axi_araddr;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  logic        low_supply_cmp_i;
  logic        bg_ready_i;
  logic        sleep_i;
  logic        bg_power_o;
  logic        high_ref_amp_en_o;
  logic        low_ref_amp_en_o;
  logic        trip_ext_sel_o;
  logic [3:0]  trip_level_o;
  logic        high_ref_pin_drive_o;
  logic        low_ref_pin_drive_o;
  logic        low_supply_irq_o;
  logic        wake_o;
  logic [4:0]  outs;
  logic [31:0] rd_val;
  int          num_errors;
  int          checks_done;
  logic [7:0]  ref_v [6] = '{8'h30, 8'h60, 8'h90, 8'h50, 8'hA0, 8'h00};
  logic [4:0]  out_v [6] = '{5'h00, 5'h14, 5'h18, 5'h15, 5'h1A, 5'h00};

  assign outs = {bg_power_o, high_ref_amp_en_o, low_ref_amp_en_o,
                 high_ref_pin_drive_o, low_ref_pin_drive_o};

  brc_ctrl #(.STARTUP_CYCLES(16)) dut (
    .clk_i, .nrst_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .low_supply_cmp_i, .bg_ready_i,
    .sleep_i, .bg_power_o, .high_ref_amp_en_o, .low_ref_amp_en_o,
    .trip_ext_sel_o, .trip_level_o, .high_ref_pin_drive_o,
    .low_ref_pin_drive_o, .low_supply_irq_o, .wake_o
  );

  always #2 clk_i = ~clk_i;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: %s got %h", $time, what, got);
    end
  endtask

  task give_verdict;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge clk_i);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
        break;
    end
    s_axi_bready <= 1'b0;
    if (n == 40)
    begin
      chk(1, 0, "write hang");
      give_verdict();
    end
    chk(s_axi_bresp, RESP_OKAY, "bresp");
  endtask

  task automatic rd(input logic [3:0] a);
    int n;
    @(posedge clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge clk_i);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
        break;
    end
    s_axi_rready <= 1'b0;
    rd_val = s_axi_rdata;
    if (n == 40)
    begin
      chk(1, 0, "read hang");
      give_verdict();
    end
    chk(s_axi_rresp, RESP_OKAY, "rresp");
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp,
                        input string what);
    rd(a);
    chk(rd_val, exp, what);
  endtask

  task automatic wait_stable;
    int n;
    for (n = 0; n < 12; n++)
    begin
      rd(REG_DET_CTRL);
      if (rd_val[BG_STABLE_BIT] === 1'b1)
        break;
    end
    chk(rd_val[BG_STABLE_BIT], 1, "stable late");
  endtask

  initial
  begin
    {clk_i, nrst_i, s_axi_awaddr, s_axi_awvalid, s_axi_wdata} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid} = '0;
    {s_axi_rready, low_supply_cmp_i, bg_ready_i, sleep_i} = '0;
    s_axi_wstrb = 4'hF;
    num_errors = 0;
    checks_done = 0;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    rd_chk(REG_REF_CTRL, 32'h0, "ref reset");
    rd_chk(REG_DET_CTRL, {28'h0, TRIP_RST}, "det reset");
    chk(outs, 0, "outs reset");
    wr(REG_REF_CTRL, 32'hFF);
    rd_chk(REG_REF_CTRL, 32'hF0, "ref low bits");
    chk(outs, 5'h1F, "refs on");
    rd_chk(REG_DET_CTRL, 32'h05, "stable early");
    wait_stable();
    for (int i = 0; i < 6; i++)
    begin
      wr(REG_REF_CTRL, {24'h0, ref_v[i]});
      rd_chk(REG_REF_CTRL, {24'h0, ref_v[i]}, "ref rb");
      chk(outs, out_v[i], "pin gating");
    end
    for (int c = 0; c < 16; c++)
    begin
      wr(REG_DET_CTRL, c);
      rd_chk(REG_DET_CTRL, c, "trip rb");
      chk({trip_ext_sel_o, trip_level_o}, {c == 15, c[3:0]}, "trip");
    end
    wr(REG_DET_CTRL, 32'hE0);
    rd_chk(REG_DET_CTRL, 32'h0, "det ro bits");
    s_axi_wstrb <= 4'h0;
    wr(REG_DET_CTRL, 32'h0F);
    s_axi_wstrb <= 4'hF;
    rd_chk(REG_DET_CTRL, 32'h0, "strobe off");
    low_supply_cmp_i <= 1'b1;
    wr(REG_DET_CTRL, 32'h05);
    wr(REG_DET_CTRL, 32'h15);
    rd_chk(REG_LOW_FLAG, 32'h0, "flag blocked");
    chk(bg_power_o, 1, "det power");
    wait_stable();
    rd_chk(REG_LOW_FLAG, 32'h1, "flag set");
    wr(REG_LOW_FLAG, 32'h2);
    rd_chk(REG_LOW_FLAG, 32'h3, "clear while low");
    chk({low_supply_irq_o, wake_o}, 2'b10, "irq");
    sleep_i <= 1'b1;
    rd_chk(REG_LOW_FLAG, 32'h3, "flag");
    chk(wake_o, 1, "wake");
    wr(REG_LOW_FLAG, 32'h0);
    rd_chk(REG_LOW_FLAG, 32'h1, "irq off");
    chk({low_supply_irq_o, wake_o}, 2'b00, "irq off");
    low_supply_cmp_i <= 1'b0;
    sleep_i <= 1'b0;
    rd_chk(REG_LOW_FLAG, 32'h1, "flag held");
    wr(REG_LOW_FLAG, 32'h0);
    rd_chk(REG_LOW_FLAG, 32'h0, "flag cleared");
    wr(REG_DET_CTRL, 32'h05);
    rd_chk(REG_DET_CTRL, 32'h05, "det off");
    chk(bg_power_o, 0, "det off power");
    wr(REG_SYS_CTRL, 32'h1);
    rd_chk(REG_SYS_CTRL, 32'h1, "brownout");
    chk(bg_power_o, 1, "brownout power");
    wr(REG_SYS_CTRL, 32'h2);
    wr(REG_REF_CTRL, 32'h80);
    rd_chk(REG_DET_CTRL, 32'h05, "macro not ready");
    bg_ready_i <= 1'b1;
    wait_stable();
    nrst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    rd_chk(REG_REF_CTRL, 32'h0, "ref reset 2");
    chk(outs, 0, "outs reset 2");
    give_verdict();
  end
endmodule
